// ### hdl/uhr_cfg.svh
`ifndef UHR_CFG_SVH
`define UHR_CFG_SVH
// Contract
// R1 - Capability bit advertises one-way reconfiguration
// R2 - Transmit and receive triggers affect own direction
// R3 - Act only in initialized or activated state
// R4 - Other states discard trigger without error
// R5 - Selection code equal on all path lanes
// R6 - Signal integrity changes on any lane subset
// R7 - Lane allocation of path must stay unchanged; checked only for one-way triggers
// R8 - Network path applications are never eligible
// R9 - Parameters come from a chosen staged set
// R10 - Status shows executing, then success or failure
// R11 - Failed validation commits nothing anywhere
// R12 - Host waits for completion before transitions
// R13 - Separate transmit and receive active records
// R14 - Legacy active set always equals transmit
// R15 - Receive mirrors transmit until one-way apply
// R16 - Both-direction trigger reconfigures both at once
// R17 - Discarded trigger changes no status or record; the code still sets the discard bit in the interrupt status
`define UHR_OFF_CAPS 6'h00
`define UHR_OFF_TRIG 6'h04
`define UHR_OFF_STATUS 6'h08
`define UHR_OFF_INT_STAT 6'h0C
`define UHR_OFF_INT_CLR 6'h10
`define UHR_OFF_INT_EN 6'h14
`define UHR_OFF_STG_APP 6'h18
`define UHR_OFF_STG_LANE 6'h1C
`define UHR_OFF_TX_APP 6'h28
`define UHR_OFF_TX_LANE 6'h2C
`define UHR_OFF_RX_APP 6'h30
`define UHR_OFF_RX_LANE 6'h34
`define UHR_OFF_LEG_APP 6'h38
`define UHR_OFF_LEG_LANE 6'h3C
`define UHR_STG_STRIDE 6'h08
`define UHR_TRIG_BOTH 0
`define UHR_TRIG_TX 1
`define UHR_TRIG_RX 2
`define UHR_TRIG_SEL 4
`define UHR_ST_INIT 3'h3
`define UHR_ST_ACT 3'h5
`define UHR_CMD_IDLE 2'h0
`define UHR_CMD_BUSY 2'h1
`define UHR_CMD_OK 2'h2
`define UHR_CMD_FAIL 2'h3
`define UHR_EV_OK 0
`define UHR_EV_FAIL 1
`define UHR_EV_DISCARD 2
`define UHR_CMD_CYCLES 4
`endif

// ### hdl/uhr_pkg.sv
package uhr_pkg;
  typedef struct packed {
    logic np;
    logic [7:0] si;
    logic [7:0] lanes;
    logic [31:0] app;
  } uhr_cfg_type;
  typedef enum {uhr_idle, uhr_busy} uhr_fsm_type;
endpackage

// ### hdl/uhr_unidir_hot_reconfig.sv
`timescale 1ns/1ps
`include "uhr_cfg.svh"
module uhr_unidir_hot_reconfig #(
  parameter int CMD_CYCLES = `UHR_CMD_CYCLES,
  parameter int SETS = 2
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [2:0] i_path_state,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  output uhr_pkg::uhr_cfg_type o_tx_cfg,
  output uhr_pkg::uhr_cfg_type o_rx_cfg,
  output uhr_pkg::uhr_cfg_type o_legacy_cfg,
  output logic o_commit_tx,
  output logic o_commit_rx
);

  // ==========================================================
  // Elaboration checks
  if (CMD_CYCLES < 1 || CMD_CYCLES > 255) begin : g_chk_cyc
    $error("CMD_CYCLES out of range");
  end
  if (SETS < 1 || SETS > 2) begin : g_chk_sets
    $error("SETS must be 1 or 2");
  end

  localparam logic [7:0] CYC_LAST = 8'(CMD_CYCLES - 1);

  function automatic logic [31:0] uhr_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Bus slave
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic wr_ok;

  // Write takes effect at the edge where waitrequest is seen low
  assign wr_ok = i_avs_write && !wait_ff;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((i_avs_read || i_avs_write) && wait_ff);
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_ff <= 32'h0;
    end else if (i_avs_read && wait_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = wait_ff;

  // ==========================================================
  // Registers
  uhr_pkg::uhr_cfg_type stg_ff [2];
  uhr_pkg::uhr_cfg_type tx_ff;
  uhr_pkg::uhr_cfg_type rx_ff;
  uhr_pkg::uhr_cfg_type pend_ff;
  uhr_pkg::uhr_fsm_type fsm_ff;
  logic [1:0] cmd_st_ff;
  logic split_ff;
  logic do_tx_ff;
  logic do_rx_ff;
  logic sel_ff;
  logic [7:0] cnt_ff;
  logic [2:0] int_stat_ff;
  logic [2:0] int_en_ff;
  logic [2:0] nxt_int_stat;
  logic [2:0] nxt_int_en;
  logic irq_ff;
  logic commit_tx_ff;
  logic commit_rx_ff;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stg_ff[0] <= '0;
      stg_ff[1] <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (wr_ok && i_avs_address == `UHR_OFF_STG_APP + 6'(k * 8)) begin
          stg_ff[k].app <= uhr_merge(stg_ff[k].app, i_avs_writedata, i_avs_byteenable);
        end
        if (wr_ok && i_avs_address == `UHR_OFF_STG_LANE + 6'(k * 8)) begin
          {stg_ff[k].np, stg_ff[k].si, stg_ff[k].lanes} <= 17'(uhr_merge(
            {15'h0, stg_ff[k].np, stg_ff[k].si, stg_ff[k].lanes},
            i_avs_writedata, i_avs_byteenable));
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_en_ff <= 3'h0;
    end else begin
      int_en_ff <= nxt_int_en;
    end
  end

  // The interrupt output uses the next enable so it follows an enable write without lag
  assign nxt_int_en = (wr_ok && i_avs_address == `UHR_OFF_INT_EN && i_avs_byteenable[0])
                      ? i_avs_writedata[2:0] : int_en_ff;

  // ==========================================================
  // Trigger decode
  logic trig_wr;
  logic trig_any;
  logic trig_both;
  logic steady;
  logic accept;
  logic discard;

  assign trig_wr = wr_ok && i_avs_address == `UHR_OFF_TRIG && i_avs_byteenable[0];
  assign trig_any = trig_wr && (i_avs_writedata[`UHR_TRIG_BOTH]
                    || i_avs_writedata[`UHR_TRIG_TX] || i_avs_writedata[`UHR_TRIG_RX]);
  assign trig_both = i_avs_writedata[`UHR_TRIG_BOTH]
                     || (i_avs_writedata[`UHR_TRIG_TX] && i_avs_writedata[`UHR_TRIG_RX]); // [R16]
  assign steady = i_path_state == `UHR_ST_INIT || i_path_state == `UHR_ST_ACT; // [R3]
  assign accept = trig_any && steady && fsm_ff == uhr_pkg::uhr_idle;
  assign discard = trig_any && !accept; // [R4] [R17]

  // ==========================================================
  // Validation of the pending set
  logic [3:0] ref_code;
  logic [7:0] lane_bad;
  logic valid;

  always_comb begin
    ref_code = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pend_ff.lanes[i]) begin
        ref_code = pend_ff.app[4*i +: 4];
      end
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_lane
    assign lane_bad[i] = pend_ff.lanes[i] && pend_ff.app[4*i +: 4] != ref_code; // [R5]
  end

  always_comb begin
    valid = 1'b1;
    if (pend_ff.lanes == 8'h0 || ref_code == 4'h0 || lane_bad != 8'h0) begin
      valid = 1'b0; // [R5]
    end
    if (pend_ff.np) begin
      valid = 1'b0; // [R8]
    end
    if ((pend_ff.si & ~pend_ff.lanes) != 8'h0) begin
      valid = 1'b0; // [R6]
    end
    if (sel_ff && SETS < 2) begin
      valid = 1'b0; // [R9]
    end
    if (!(do_tx_ff && do_rx_ff)) begin
      if (do_tx_ff && pend_ff.lanes != tx_ff.lanes) begin
        valid = 1'b0; // [R7]
      end
      if (do_rx_ff && pend_ff.lanes != rx_ff.lanes) begin
        valid = 1'b0; // [R7]
      end
    end
  end

  // ==========================================================
  // Command sequencer
  logic finish;

  assign finish = fsm_ff == uhr_pkg::uhr_busy && cnt_ff == 8'h0;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fsm_ff <= uhr_pkg::uhr_idle;
      cnt_ff <= 8'h0;
    end else begin
      case (fsm_ff)
        uhr_pkg::uhr_idle: begin
          if (accept) begin
            fsm_ff <= uhr_pkg::uhr_busy;
            cnt_ff <= CYC_LAST;
          end
        end
        uhr_pkg::uhr_busy: begin
          if (cnt_ff == 8'h0) begin
            fsm_ff <= uhr_pkg::uhr_idle;
          end else begin
            cnt_ff <= cnt_ff - 8'h1;
          end
        end
        default: begin
          fsm_ff <= uhr_pkg::uhr_idle;
        end
      endcase
    end
  end

  // The command is latched at acceptance so later staging writes cannot disturb it
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      do_tx_ff <= 1'b0;
      do_rx_ff <= 1'b0;
      sel_ff <= 1'b0;
      pend_ff <= '0;
    end else if (accept) begin
      sel_ff <= i_avs_writedata[`UHR_TRIG_SEL];
      pend_ff <= stg_ff[i_avs_writedata[`UHR_TRIG_SEL]]; // [R9]
      do_tx_ff <= trig_both || i_avs_writedata[`UHR_TRIG_TX]; // [R2]
      do_rx_ff <= trig_both || i_avs_writedata[`UHR_TRIG_RX]; // [R2]
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_st_ff <= `UHR_CMD_IDLE;
    end else if (accept) begin
      cmd_st_ff <= `UHR_CMD_BUSY; // [R10]
    end else if (finish) begin
      cmd_st_ff <= valid ? `UHR_CMD_OK : `UHR_CMD_FAIL; // [R10]
    end
  end

  // ==========================================================
  // Active records
  // Records change only when a validated command finishes
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_ff <= '0;
    end else if (finish && valid && do_tx_ff) begin // [R11]
      tx_ff <= pend_ff; // [R13]
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_ff <= '0;
    end else if (finish && valid && do_rx_ff) begin // [R11]
      rx_ff <= pend_ff; // [R13]
    end
  end

  // Set by a one-way commit, cleared when both directions are applied again
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      split_ff <= 1'b0;
    end else if (finish && valid) begin
      split_ff <= !(do_tx_ff && do_rx_ff); // [R15]
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      commit_tx_ff <= 1'b0;
    end else begin
      commit_tx_ff <= finish && valid && do_tx_ff; // [R11]
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      commit_rx_ff <= 1'b0;
    end else begin
      commit_rx_ff <= finish && valid && do_rx_ff; // [R11]
    end
  end

  assign o_tx_cfg = tx_ff;
  assign o_rx_cfg = rx_ff;
  assign o_legacy_cfg = tx_ff; // [R14]
  assign o_commit_tx = commit_tx_ff;
  assign o_commit_rx = commit_rx_ff;

  // ==========================================================
  // Interrupts
  logic [2:0] ev;
  logic [2:0] clr;

  always_comb begin
    ev = 3'h0;
    ev[`UHR_EV_OK] = finish && valid;
    ev[`UHR_EV_FAIL] = finish && !valid;
    ev[`UHR_EV_DISCARD] = discard;
  end

  assign clr = (wr_ok && i_avs_address == `UHR_OFF_INT_CLR && i_avs_byteenable[0])
               ? i_avs_writedata[2:0] : 3'h0;
  // A new event beats a clear in the same cycle
  assign nxt_int_stat = (int_stat_ff & ~clr) | ev;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      int_stat_ff <= nxt_int_stat;
      irq_ff <= |(nxt_int_stat & nxt_int_en);
    end
  end

  assign o_irq = irq_ff;

  // ==========================================================
  // Read mux
  always_comb begin
    rd_mux = 32'h0;
    case (i_avs_address)
      `UHR_OFF_CAPS: begin
        rd_mux = {30'h0, SETS == 2, 1'b1}; // [R1]
      end
      `UHR_OFF_STATUS: begin
        rd_mux = {25'h0, i_path_state, 1'b0, split_ff, cmd_st_ff}; // [R10]
      end
      `UHR_OFF_INT_STAT: begin
        rd_mux = {29'h0, int_stat_ff};
      end
      `UHR_OFF_INT_EN: begin
        rd_mux = {29'h0, int_en_ff};
      end
      `UHR_OFF_STG_APP: begin
        rd_mux = stg_ff[0].app;
      end
      `UHR_OFF_STG_LANE: begin
        rd_mux = {15'h0, stg_ff[0].np, stg_ff[0].si, stg_ff[0].lanes};
      end
      `UHR_OFF_STG_APP + `UHR_STG_STRIDE: begin
        rd_mux = stg_ff[1].app;
      end
      `UHR_OFF_STG_LANE + `UHR_STG_STRIDE: begin
        rd_mux = {15'h0, stg_ff[1].np, stg_ff[1].si, stg_ff[1].lanes};
      end
      `UHR_OFF_TX_APP, `UHR_OFF_LEG_APP: begin
        rd_mux = tx_ff.app; // [R14]
      end
      `UHR_OFF_TX_LANE, `UHR_OFF_LEG_LANE: begin
        rd_mux = {15'h0, tx_ff.np, tx_ff.si, tx_ff.lanes}; // [R14]
      end
      `UHR_OFF_RX_APP: begin
        rd_mux = rx_ff.app;
      end
      `UHR_OFF_RX_LANE: begin
        rd_mux = {15'h0, rx_ff.np, rx_ff.si, rx_ff.lanes};
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

endmodule

// ### verification/uhr_host_model.sv
`timescale 1ns/1ps
module uhr_host_model (
  input wire logic i_mclk,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [5:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  initial begin
    o_address = 6'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
    o_byteenable = 4'hF;
  end
  // Released address and write data lines show inverted values so stale data is never mistaken for valid
  task automatic wr_be(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge i_mclk);
    o_address <= a;
    o_writedata <= d;
    o_byteenable <= b;
    o_write <= 1'b1;
    do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
    o_write <= 1'b0;
    o_address <= ~a;
    o_writedata <= ~d;
    o_byteenable <= 4'hF;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wr_be(a, d, 4'hF);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    o_address <= a;
    o_read <= 1'b1;
    do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
    d = i_readdata;
    o_read <= 1'b0;
    o_address <= ~a;
  endtask
endmodule

// ### verification/uhr_unidir_hot_reconfig_assertions.sv
`timescale 1ns/1ps
`include "uhr_cfg.svh"
module uhr_reconfig_checker #(
  parameter int CMD_CYCLES = 4,
  parameter int SETS = 2
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [2:0] i_path_state,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_irq,
  input wire uhr_pkg::uhr_cfg_type o_tx_cfg,
  input wire uhr_pkg::uhr_cfg_type o_rx_cfg,
  input wire uhr_pkg::uhr_cfg_type o_legacy_cfg,
  input wire logic o_commit_tx,
  input wire logic o_commit_rx
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // ==========================================
  // Bus timing
  a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("access not answered after one wait state");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rdata_on_read: assert property (!$stable(o_avs_readdata) |-> $past(i_avs_read))
    else $error("read data changed without a read");
  // ==========================================
  // Records and commits
  a_legacy_tx: assert property (o_legacy_cfg == o_tx_cfg)
    else $error("legacy record differs from transmit record");
  a_tx_via_commit: assert property (!$stable(o_tx_cfg) |-> o_commit_tx)
    else $error("transmit record changed without commit");
  a_rx_via_commit: assert property (!$stable(o_rx_cfg) |-> o_commit_rx)
    else $error("receive record changed without commit");
  a_commit_pulse: assert property (o_commit_tx || o_commit_rx |=> !o_commit_tx && !o_commit_rx)
    else $error("commit pulse longer than one cycle");
  a_commit_steady: assert property (o_commit_tx || o_commit_rx |->
    i_path_state inside {`UHR_ST_INIT, `UHR_ST_ACT})
    else $error("commit outside a steady path state");
  a_both_equal: assert property (o_commit_tx && o_commit_rx |-> o_rx_cfg == o_tx_cfg)
    else $error("both-direction commit left records different");
  a_tx_lanes_kept: assert property (o_commit_tx && !o_commit_rx |-> o_tx_cfg.lanes == $past(o_tx_cfg.lanes))
    else $error("one-way transmit commit changed the lanes");
  a_rx_lanes_kept: assert property (o_commit_rx && !o_commit_tx |-> o_rx_cfg.lanes == $past(o_rx_cfg.lanes))
    else $error("one-way receive commit changed the lanes");
  a_commit_no_np: assert property (o_commit_tx || o_commit_rx |-> !o_tx_cfg.np && !o_rx_cfg.np)
    else $error("network path set was committed");
endmodule
bind uhr_unidir_hot_reconfig uhr_reconfig_checker #(.CMD_CYCLES(CMD_CYCLES), .SETS(SETS)) uhr_reconfig_checker_inst (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .i_path_state(i_path_state), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_irq(o_irq), .o_tx_cfg(o_tx_cfg), .o_rx_cfg(o_rx_cfg), .o_legacy_cfg(o_legacy_cfg),
  .o_commit_tx(o_commit_tx), .o_commit_rx(o_commit_rx));

// ### verification/uhr_unidir_hot_reconfig_test.sv
`timescale 1ns/1ps
`include "uhr_cfg.svh"
module uhr_unidir_hot_reconfig_test;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] path_state = `UHR_ST_INIT;
  logic [5:0] addr;
  logic rd, wr, wait_req, irq, commit_tx, commit_rx;
  logic [31:0] wdata, rdata, v;
  logic [3:0] be;
  uhr_pkg::uhr_cfg_type tx_cfg, rx_cfg, leg_cfg;
  int n_mismatch = 0;
  int compares = 0;
  int n_commit_tx = 0;
  int n_commit_rx = 0;
  // Case table: staged app, staged lane word, trigger, status, tx app, rx app, rx lane word
  logic [31:0] t_app [0:6] = '{32'h1111, 32'h2222, 32'h1211, 32'h3333, 32'h3333, 32'h3333, 32'h4444};
  logic [31:0] t_lane [0:6] = '{32'h000F, 32'h0F0F, 32'h000F, 32'h0003, 32'h1000F, 32'h010F, 32'h000F};
  logic [31:0] t_trig [0:6] = '{32'h01, 32'h12, 32'h04, 32'h04, 32'h04, 32'h04, 32'h01};
  logic [31:0] t_st [0:6] = '{32'h2, 32'h2, 32'h3, 32'h3, 32'h3, 32'h2, 32'h2};
  logic [31:0] t_tx [0:6] = '{32'h1111, 32'h2222, 32'h2222, 32'h2222, 32'h2222, 32'h2222, 32'h4444};
  logic [31:0] t_rx [0:6] = '{32'h1111, 32'h1111, 32'h1111, 32'h1111, 32'h1111, 32'h3333, 32'h4444};
  logic [31:0] t_rxl [0:6] = '{32'h000F, 32'h000F, 32'h000F, 32'h000F, 32'h000F, 32'h010F, 32'h000F};
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Count commit pulses; each stands for exactly one cycle
  always @(posedge mclk) begin
    if (commit_tx === 1'b1) n_commit_tx <= n_commit_tx + 1;
    if (commit_rx === 1'b1) n_commit_rx <= n_commit_rx + 1;
  end
  uhr_unidir_hot_reconfig #(.CMD_CYCLES(4), .SETS(2)) uhr_unidir_hot_reconfig_inst (
    .i_mclk(mclk), .i_reset_n(reset_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .i_path_state(path_state), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_irq(irq), .o_tx_cfg(tx_cfg), .o_rx_cfg(rx_cfg), .o_legacy_cfg(leg_cfg),
    .o_commit_tx(commit_tx), .o_commit_rx(commit_rx));
  uhr_host_model uhr_host_model_inst (.i_mclk(mclk), .i_waitrequest(wait_req), .i_readdata(rdata),
    .o_address(addr), .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Poll status until the command leaves busy
  task wait_done;
    int n;
    n = 0;
    v = 32'h1;
    while (v[1:0] === `UHR_CMD_BUSY && n < 100) begin
      uhr_host_model_inst.rd(`UHR_OFF_STATUS, v);
      n++;
    end
    if (v[1:0] === `UHR_CMD_BUSY) check(v, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    uhr_host_model_inst.rd(`UHR_OFF_CAPS, v);
    check(v & 32'h3, 32'h3);
    uhr_host_model_inst.rd(6'h01, v);
    check(v, 32'h0);
    uhr_host_model_inst.wr(`UHR_OFF_INT_EN, 32'h7);
    for (int i = 0; i < 7; i++) begin
      uhr_host_model_inst.wr(`UHR_OFF_STG_APP + (t_trig[i][4] ? `UHR_STG_STRIDE : 6'h00), t_app[i]);
      uhr_host_model_inst.wr(`UHR_OFF_STG_LANE + (t_trig[i][4] ? `UHR_STG_STRIDE : 6'h00), t_lane[i]);
      path_state <= i[0] ? `UHR_ST_ACT : `UHR_ST_INIT;
      uhr_host_model_inst.wr(`UHR_OFF_TRIG, t_trig[i]);
      wait_done;
      check(v & 32'h3, t_st[i]);
      check({31'h0, v[2]}, {31'h0, t_tx[i] != t_rx[i]});
      check(tx_cfg.app, t_tx[i]);
      check(rx_cfg.app, t_rx[i]);
      check(leg_cfg.app, t_tx[i]);
      check({15'h0, rx_cfg.np, rx_cfg.si, rx_cfg.lanes}, t_rxl[i]);
      uhr_host_model_inst.rd(`UHR_OFF_RX_APP, v);
      check(v, t_rx[i]);
      uhr_host_model_inst.rd(`UHR_OFF_LEG_APP, v);
      check(v, t_tx[i]);
      uhr_host_model_inst.rd(`UHR_OFF_INT_STAT, v);
      check(v, (t_st[i] == 32'h2) ? 32'h1 : 32'h2);
      check({31'h0, irq}, 32'h1);
      uhr_host_model_inst.wr(`UHR_OFF_INT_CLR, 32'h7);
      $display("case %0d done", i);
    end
    uhr_host_model_inst.rd(`UHR_OFF_INT_STAT, v);
    check(v, 32'h0);
    check({31'h0, irq}, 32'h0);
    uhr_host_model_inst.wr(`UHR_OFF_INT_EN, 32'h0);
    path_state <= 3'h1;
    uhr_host_model_inst.wr(`UHR_OFF_TRIG, 32'h02);
    repeat (8) @(posedge mclk);
    uhr_host_model_inst.rd(`UHR_OFF_STATUS, v);
    check(v & 32'h3, 32'h2);
    check(tx_cfg.app, 32'h4444);
    uhr_host_model_inst.rd(`UHR_OFF_INT_STAT, v);
    check(v, 32'h4);
    check({31'h0, irq}, 32'h0);
    uhr_host_model_inst.wr(`UHR_OFF_INT_EN, 32'h4);
    uhr_host_model_inst.rd(`UHR_OFF_CAPS, v);
    check({31'h0, irq}, 32'h1);
    $display("discard test done");
    uhr_host_model_inst.wr(`UHR_OFF_INT_CLR, 32'h7);
    uhr_host_model_inst.wr_be(`UHR_OFF_STG_APP, 32'hFFFF5555, 4'h3);
    uhr_host_model_inst.rd(`UHR_OFF_STG_APP, v);
    check(v, 32'h00005555);
    path_state <= `UHR_ST_ACT;
    uhr_host_model_inst.wr(`UHR_OFF_TRIG, 32'h06);
    uhr_host_model_inst.wr(`UHR_OFF_TRIG, 32'h02);
    wait_done;
    check(v & 32'h7, 32'h2);
    check(tx_cfg.app, 32'h5555);
    check(rx_cfg.app, 32'h5555);
    uhr_host_model_inst.rd(`UHR_OFF_INT_STAT, v);
    check(v, 32'h5);
    check(n_commit_tx, 32'h4);
    check(n_commit_rx, 32'h4);
    $display("busy and both-bit test done");
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end
endmodule
